/* hw/fsmux_regs.svh */
// register offsets, fields and reset values of the fan source mux
// assumes an 8-bit register port with byte addresses as printed
`ifndef FSMUX_REGS_SVH
`define FSMUX_REGS_SVH
// Function
// - each of three fan outputs has a 3-bit behaviour field in bits 7:5.
// - codes 000, 001, 010 take duty from remote 1, local, remote 2.
// - code 101 drives the larger of local and remote 2 duty.
// - code 110 drives the largest of all three channel duties.
// - code 011 drives full speed regardless of temperature.
// - code 100 disables the output and is the reset value of each field.
// - code 111 makes the live duty register writable and drive the output.
// - each channel duty is calibrated alone; any channel can start a fan.
// - live duty is 8 bits, linear from 0% to 100% in about 0.39% steps.
// - reading live duty returns the duty actually driven.
// - overtemperature forces full duty even in manual mode.
`define FSMUX_LIVE_DUTY1 8'h30
`define FSMUX_LIVE_DUTY2 8'h31
`define FSMUX_LIVE_DUTY3 8'h32
`define FSMUX_CFG1 8'h5C
`define FSMUX_CFG2 8'h5D
`define FSMUX_CFG3 8'h5E
`define FSMUX_BHV_HI 7
`define FSMUX_BHV_LO 5
`define FSMUX_CFG_RESET 8'h80
`define FSMUX_DUTY_FULL 8'hFF
`define FSMUX_DUTY_OFF 8'h00
`define FSMUX_MANUAL_RESET 8'hFF
`define FSMUX_READ_IDLE 8'h00
`endif

/* hw/fsmux_pkg.sv */
// types of the fan source mux
// assumes fsmux_regs.svh supplies the numeric constants
package fsmux_pkg;
  typedef enum logic [2:0] {
    FSMUX_REMOTE1 = 3'b000,
    FSMUX_LOCAL = 3'b001,
    FSMUX_REMOTE2 = 3'b010,
    FSMUX_FULL = 3'b011,
    FSMUX_OFF = 3'b100,
    FSMUX_MAX_LR2 = 3'b101,
    FSMUX_MAX_ALL = 3'b110,
    FSMUX_MANUAL = 3'b111
  } fsmux_behavior_t;
  typedef logic [7:0] fsmux_duty_t;
endpackage

/* hw/fsmux_top.sv */
// behaviour mux choosing the duty source of three fan drive outputs
// assumes channel duties come from per-channel calibration upstream and
// a simple synchronous 8-bit register port
`timescale 1ns/100ps
`include "fsmux_regs.svh"
module fsmux_top #(
  parameter int NUM_FANS = 3
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire fsmux_pkg::fsmux_duty_t REG_WDATA,
  output fsmux_pkg::fsmux_duty_t REG_RDATA,
  // per-channel calculated duty: remote 1, local, remote 2
  input wire fsmux_pkg::fsmux_duty_t REMOTE1_DUTY,
  input wire fsmux_pkg::fsmux_duty_t LOCAL_DUTY,
  input wire fsmux_pkg::fsmux_duty_t REMOTE2_DUTY,
  // overtemperature level
  input wire logic OVERTEMP_SIGNAL,
  // duty driven on each fan drive output, and its enable
  output fsmux_pkg::fsmux_duty_t FAN_DRIVE_OUTPUT [NUM_FANS],
  output logic [NUM_FANS-1:0] FAN_DRIVE_ENABLE
);
  import fsmux_pkg::*;

  // register state
  logic [7:0] cfg [NUM_FANS];
  logic [7:0] next_cfg [NUM_FANS];
  fsmux_duty_t manual [NUM_FANS];
  fsmux_duty_t next_manual [NUM_FANS];

  // drive state
  fsmux_duty_t duty [NUM_FANS];
  fsmux_duty_t next_duty [NUM_FANS];
  logic [NUM_FANS-1:0] enable;
  logic [NUM_FANS-1:0] next_enable;

  // read port state
  fsmux_duty_t rdata;
  fsmux_duty_t next_rdata;

  // decoded behaviour, register hits and mux result per fan
  fsmux_behavior_t bhv [NUM_FANS];
  logic [NUM_FANS-1:0] cfg_hit;
  logic [NUM_FANS-1:0] duty_hit;
  logic [NUM_FANS-1:0] cfg_wr;
  logic [NUM_FANS-1:0] duty_wr;
  logic [NUM_FANS-1:0] manual_mode;
  logic [NUM_FANS-1:0] force_full;
  fsmux_duty_t src_duty [NUM_FANS];
  fsmux_duty_t read_word;

  // shared channel maxima
  fsmux_duty_t max_lr2;
  fsmux_duty_t max_all;

  // each channel is already calibrated on its own, so max picks any demand
  assign max_lr2 = (LOCAL_DUTY > REMOTE2_DUTY) ?
    LOCAL_DUTY : REMOTE2_DUTY;
  assign max_all = (max_lr2 > REMOTE1_DUTY) ?
    max_lr2 : REMOTE1_DUTY;

  function automatic logic [7:0] cfg_addr(input int i);
    cfg_addr = `FSMUX_CFG1 + 8'(i);
  endfunction

  function automatic logic [7:0] duty_addr(input int i);
    duty_addr = `FSMUX_LIVE_DUTY1 + 8'(i);
  endfunction

  // behaviour field split and mode flags
  always_comb begin
    for (int i = 0; i < NUM_FANS; i++) begin
      bhv[i] = fsmux_behavior_t'(cfg[i][`FSMUX_BHV_HI:`FSMUX_BHV_LO]);
      manual_mode[i] = (bhv[i] == FSMUX_MANUAL);
      // fail-safe cooling beats every mode except a disabled output
      force_full[i] = OVERTEMP_SIGNAL && (bhv[i] != FSMUX_OFF);
    end
  end

  // register address decode
  always_comb begin
    for (int i = 0; i < NUM_FANS; i++) begin
      cfg_hit[i] = (REG_ADDR == cfg_addr(i));
      duty_hit[i] = (REG_ADDR == duty_addr(i));
      cfg_wr[i] = REG_WR && cfg_hit[i];
      // writes outside manual mode are dropped without any flag
      duty_wr[i] = REG_WR && duty_hit[i] && manual_mode[i];
    end
  end

  // config group: all 8 bits kept, only the field steers the mux
  always_comb begin
    for (int i = 0; i < NUM_FANS; i++) begin
      next_cfg[i] = cfg[i];
      if (cfg_wr[i]) begin
        next_cfg[i] = REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_FANS; i++) begin
        cfg[i] <= `FSMUX_CFG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_FANS; i++) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  // manual group: kept apart so automatic modes never disturb it
  always_comb begin
    for (int i = 0; i < NUM_FANS; i++) begin
      next_manual[i] = manual[i];
      if (duty_wr[i]) begin
        next_manual[i] = REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_FANS; i++) begin
        manual[i] <= `FSMUX_MANUAL_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_FANS; i++) begin
        manual[i] <= next_manual[i];
      end
    end
  end

  // source mux: the duty that the behaviour field asks for
  always_comb begin
    for (int i = 0; i < NUM_FANS; i++) begin
      unique case (bhv[i])
        FSMUX_REMOTE1: src_duty[i] = REMOTE1_DUTY;
        FSMUX_LOCAL: src_duty[i] = LOCAL_DUTY;
        FSMUX_REMOTE2: src_duty[i] = REMOTE2_DUTY;
        FSMUX_FULL: src_duty[i] = `FSMUX_DUTY_FULL;
        FSMUX_OFF: src_duty[i] = `FSMUX_DUTY_OFF;
        FSMUX_MAX_LR2: src_duty[i] = max_lr2;
        FSMUX_MAX_ALL: src_duty[i] = max_all;
        FSMUX_MANUAL: src_duty[i] = manual[i];
      endcase
    end
  end

  // drive group: one register stage between the mux and the pin
  always_comb begin
    for (int i = 0; i < NUM_FANS; i++) begin
      next_duty[i] = src_duty[i];
      if (force_full[i]) begin
        next_duty[i] = `FSMUX_DUTY_FULL;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NUM_FANS; i++) begin
        duty[i] <= `FSMUX_DUTY_OFF;
      end
    end else begin
      for (int i = 0; i < NUM_FANS; i++) begin
        duty[i] <= next_duty[i];
      end
    end
  end

  // enable group: only the disabled code turns the output off
  always_comb begin
    for (int i = 0; i < NUM_FANS; i++) begin
      next_enable[i] = (bhv[i] != FSMUX_OFF);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable <= '0;
    end else begin
      enable <= next_enable;
    end
  end

  // read mux: live duty reads give the driven duty, not the manual value
  always_comb begin
    read_word = `FSMUX_READ_IDLE;
    for (int i = 0; i < NUM_FANS; i++) begin
      if (duty_hit[i]) begin
        read_word = duty[i];
      end
      if (cfg_hit[i]) begin
        read_word = cfg[i];
      end
    end
  end

  // read group: the word is held until the next read strobe
  always_comb begin
    next_rdata = rdata;
    if (REG_RD) begin
      next_rdata = read_word;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata <= `FSMUX_READ_IDLE;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign FAN_DRIVE_OUTPUT = duty;
  assign FAN_DRIVE_ENABLE = enable;
  assign REG_RDATA = rdata;
endmodule // fsmux_top

/* dv/fsmux_fan_model.sv */
// fan model: spins while enabled with nonzero duty
// assumes one fan drive output feeds it
`timescale 1ns/100ps
module fsmux_fan_model (
  // drive
  input wire fsmux_pkg::fsmux_duty_t duty,
  input wire logic en,
  // sense
  output logic spin
);
  import fsmux_pkg::*;
  assign spin = en && (duty != 8'h00);
endmodule // fsmux_fan_model

/* dv/fsmux_checker.sv */
// assertions on fan 1 of the mux
// assumes config changes only through REG_WR
`timescale 1ns/100ps
module fsmux_checker #(parameter int NUM_FANS = 3) (
  // clock, register port
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REG_WR,
  input wire logic [7:0] REG_ADDR,
  input wire fsmux_pkg::fsmux_duty_t REG_WDATA,
  // channels, outputs
  input wire fsmux_pkg::fsmux_duty_t REMOTE1_DUTY,
  input wire fsmux_pkg::fsmux_duty_t LOCAL_DUTY,
  input wire fsmux_pkg::fsmux_duty_t REMOTE2_DUTY,
  input wire logic OVERTEMP_SIGNAL,
  input wire fsmux_pkg::fsmux_duty_t FAN_DRIVE_OUTPUT [NUM_FANS],
  input wire logic [NUM_FANS-1:0] FAN_DRIVE_ENABLE
);
  import fsmux_pkg::*;
  logic [2:0] bhv, next_bhv;
  fsmux_duty_t m2, m3, f;
  logic ok;
  fsmux_duty_t man, next_man;
  assign m2 = LOCAL_DUTY > REMOTE2_DUTY ? LOCAL_DUTY : REMOTE2_DUTY;
  assign m3 = REMOTE1_DUTY > m2 ? REMOTE1_DUTY : m2;
  assign f = FAN_DRIVE_OUTPUT[0];
  assign ok = !OVERTEMP_SIGNAL;
  always_comb next_bhv = (REG_WR && REG_ADDR == 8'h5C) ? REG_WDATA[7:5] : bhv;
  always_comb next_man = (REG_WR && REG_ADDR == 8'h30 &&
    bhv == FSMUX_MANUAL) ? REG_WDATA : man;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bhv <= 3'h4;
      man <= 8'hFF;
    end else begin
      bhv <= next_bhv;
      man <= next_man;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  off_drive_a: assert property (bhv == FSMUX_OFF |=>
    f == 8'h00 && !FAN_DRIVE_ENABLE[0]) else $error("off drive");
  remote1_src_a: assert property (bhv == FSMUX_REMOTE1 && ok |=>
    f == $past(REMOTE1_DUTY)) else $error("remote 1 source");
  local_src_a: assert property (bhv == FSMUX_LOCAL && ok |=>
    f == $past(LOCAL_DUTY)) else $error("local source");
  remote2_src_a: assert property (bhv == FSMUX_REMOTE2 && ok |=>
    f == $past(REMOTE2_DUTY)) else $error("remote 2 source");
  max_pair_a: assert property (bhv == FSMUX_MAX_LR2 && ok |=>
    f == $past(m2)) else $error("pair max");
  max_all_a: assert property (bhv == FSMUX_MAX_ALL && ok |=>
    f == $past(m3)) else $error("triple max");
  full_speed_a: assert property (bhv == FSMUX_FULL |=>
    f == 8'hFF && FAN_DRIVE_ENABLE[0]) else $error("full speed");
  ot_force_a: assert property (!ok && bhv != FSMUX_OFF |=>
    f == 8'hFF) else $error("overtemp force");
  manual_drive_a: assert property (bhv == FSMUX_MANUAL && ok |=>
    f == $past(man)) else $error("manual drive");
  drive_enable_a: assert property (bhv != FSMUX_OFF |=>
    FAN_DRIVE_ENABLE[0]) else $error("drive enable");
  cover property (bhv == FSMUX_MANUAL && !ok);
  cover property (bhv == FSMUX_MAX_ALL);
  cover property (bhv == FSMUX_FULL);
endmodule // fsmux_checker
bind fsmux_top fsmux_checker #(.NUM_FANS(NUM_FANS)) u_fsmux_checker (
  .CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REMOTE1_DUTY(REMOTE1_DUTY),
  .LOCAL_DUTY(LOCAL_DUTY), .REMOTE2_DUTY(REMOTE2_DUTY),
  .OVERTEMP_SIGNAL(OVERTEMP_SIGNAL), .FAN_DRIVE_OUTPUT(FAN_DRIVE_OUTPUT),
  .FAN_DRIVE_ENABLE(FAN_DRIVE_ENABLE));

/* dv/fsmux_top_tb.sv */
// self-checking bench of the fan source mux
// assumes reads answer one cycle after the strobe
`timescale 1ns/100ps
module fsmux_top_tb;
  import fsmux_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ot = 0, spin;
  logic [7:0] addr = 0;
  logic [2:0] en;
  fsmux_duty_t wdata = 0, rdata, r1 = 8'h90, lo = 8'h42, r2 = 8'h63;
  fsmux_duty_t fan [3];
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #5 clk = ~clk;
  fsmux_top u_fsmux_top (.CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REMOTE1_DUTY(r1), .LOCAL_DUTY(lo), .REMOTE2_DUTY(r2),
    .OVERTEMP_SIGNAL(ot), .FAN_DRIVE_OUTPUT(fan), .FAN_DRIVE_ENABLE(en));
  fsmux_fan_model u_fsmux_fan_model (.duty(fan[0]), .en(en[0]), .spin(spin));
  task automatic chk(input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(negedge clk) {wr, addr, wdata} = {1'b1, a, d};
    @(negedge clk) wr = 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    @(negedge clk) {rd, addr} = {1'b1, a};
    @(negedge clk) rd = 0;
    @(negedge clk) chk(rdata, exp);
  endtask
  task automatic t_modes;
    fsmux_duty_t e [7] = '{8'h90, 8'h42, 8'h63, 8'hFF, 8'h00, 8'h63, 8'h90};
    rd_chk(8'h5C, 8'h80);
    rd_chk(8'h7F, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr_reg(8'h5C, 8'(i << 5));
      chk(fan[0], e[i]);
    end
    wr_reg(8'h5D, 8'h60);
    chk(fan[1], 8'hFF);
    wr_reg(8'h5E, 8'h40);
    chk(fan[2], 8'h63);
    chk({5'h00, en}, 8'h07);
    chk({7'h00, spin}, 8'h01);
    rd_chk(8'h30, 8'h90);
    @(negedge clk) lo = 8'hC0;
    repeat (2) @(negedge clk);
    chk(fan[0], 8'hC0);
    wr_reg(8'h5C, 8'hA0);
    chk(fan[0], 8'hC0);
  endtask
  task automatic t_manual;
    wr_reg(8'h30, 8'h11);
    chk(fan[0], 8'hC0);
    wr_reg(8'h5C, 8'hE0);
    chk(fan[0], 8'hFF);
    wr_reg(8'h30, 8'h40);
    chk(fan[0], 8'h40);
    rd_chk(8'h30, 8'h40);
    @(negedge clk) ot = 1;
    repeat (2) @(negedge clk);
    chk(fan[0], 8'hFF);
  endtask
  task automatic t_reset;
    @(negedge clk) rst_n = 0;
    repeat (5) @(negedge clk);
    chk({5'h00, en}, 8'h00);
    chk(fan[2], 8'h00);
    rst_n = 1;
    rd_chk(8'h5E, 8'h80);
    chk(fan[0], 8'h00);
    ot = 0;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    t_modes;
    t_manual;
    t_reset;
    finish_test;
  end
endmodule // fsmux_top_tb
